// ### supply_mode_supervisor.sv
// Purpose: Power-up, supply monitor and register default supervisor
// Assumes: Supply monitor levels and pins are asynchronous to clk
// Notes: Fault and open-load events come from logic on clk
//
// Contract
// - Operate only with a supply present and an input or idle pin high.
// - Power-up starts when battery or logic supply is sufficient.
// - After power-up battery and low-range flags both read set.
// - Logic undervoltage forces defaults and silences the serial port.
// - Latched fault memory survives logic undervoltage and stays readable.
// - Battery present with logic undervoltage still allows direct-input control.
// - Turn-on only while the battery monitor reports sufficient voltage.
// - Channels on during a battery dip stay on until commanded off.
// - Low-range flag sits at diagnostic bit 13, set during power-up.
// - Low-range flag is set while logic supply is in low window.
// - Only a diagnostic word read clears the low-range flag.
// - Reset turns outputs off and selects plain latch-off on overload.
// - Reset maps input 0 to channel 2 and input 1 to 3.
// - Reset input status shows failed transmission and inputs low.
// - Reset disables open-load current and open-load result reads normal.
// - Reset leaves on-state open-load selection inactive.
// - Reset shows output level monitor below threshold.
// - Reset hardware configuration normal, latch-clear holds nothing pending.
// - Logic undervoltage with battery in crank range blocks serial control.
// - Four modes: sleep, idle, active and limp home.
// - Idle low with an input high enters limp home, inputs drive 2/3; the code also requires battery ok to enter.
// - Limp home makes serial read-only and keeps open-load current off.
// - Limp entry sets supply flags, clears open-load, frame error once.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "supply_mode_supervisor_defines.svh"
`default_nettype none

module supply_mode_supervisor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Supply monitors
    input wire logic logic_supply_ok,
    input wire logic logic_supply_low_range_level,
    input wire logic battery_supply_ok,
    input wire logic battery_above_crank,
    // Pins
    input wire logic direct_input_0,
    input wire logic direct_input_1,
    input wire logic idle_pin,
    input wire logic [7:0] vout_above_threshold,
    // Events from the diagnostic logic
    input wire logic [7:0] fault_event,
    input wire logic [7:0] on_openload_event,
    input wire logic [7:0] off_openload_event,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Outputs
    output logic [7:0] channel_on,
    output logic [7:0] inrush_restart_select,
    output logic [7:0] openload_current_enable,
    output logic [3:0] on_openload_select,
    output logic [3:0] hardware_configuration,
    output supply_mode_supervisor_pkg::mode_t mode,
    output logic logic_running
);
    import supply_mode_supervisor_pkg::*;

    st_t cur_r;
    st_t cur_nxt;
    logic [`PIN_COUNT-1:0] pins;

    assign pins = {vout_above_threshold, idle_pin, direct_input_1,
                   direct_input_0, battery_above_crank, battery_supply_ok,
                   logic_supply_low_range_level, logic_supply_ok};

    function automatic logic limp_request(input logic idle_in,
                                          input logic in0,
                                          input logic in1);
        limp_request = !idle_in && (in0 || in1);
    endfunction : limp_request

    // ------------------------------------------------------------
    // Defaults of the serial-visible registers
    // ------------------------------------------------------------
    function automatic st_t load_defaults(input st_t s);
        st_t d;
        d = s;
        d.out_ctrl = `RST_OUT_CTRL;
        d.inrush_sel = `RST_INRUSH;
        d.map0 = `RST_MAP0;
        d.map1 = `RST_MAP1;
        d.frame_err = 1'b1;
        d.in_pins = 2'h0;
        d.ol_current = `RST_OL_CURRENT;
        d.on_openload_flag_res = `RST_ON_OPENLOAD_FLAG_RES;
        d.on_openload_flag_sel = `RST_ON_OPENLOAD_FLAG_SEL;
        d.level_mon = `RST_LEVEL_MON;
        d.hw_cfg = `RST_HW_CFG;
        d.latch_clr = `RST_LATCH_CLR;
        d.low_range_flag = 1'b1;
        d.bat_uv_flag = 1'b1;
        d.off_openload_flag_flag = 1'b0;
        d.rdata = 16'h0000;
        load_defaults = d;
    endfunction : load_defaults

    logic vdd_ok;
    logic vs_ok;
    logic in0;
    logic in1;
    logic idle_in;
    logic powered;
    logic serial_on;
    logic serial_wr_ok;
    logic diag_read;
    logic any_read;
    logic limp_entry;
    logic [7:0] want_on;
    logic [15:0] rd_val;

    assign vdd_ok = cur_r.filt[`PIN_VDD_OK];
    assign vs_ok = cur_r.filt[`PIN_VS_OK];
    assign in0 = cur_r.filt[`PIN_IN0];
    assign in1 = cur_r.filt[`PIN_IN1];
    assign idle_in = cur_r.filt[`PIN_IDLE];

    assign powered = (vdd_ok || vs_ok) && (in0 || in1 || idle_in);

    // no serial control without logic supply
    assign serial_on = vdd_ok && (cur_r.mode != MODE_SLEEP);
    assign serial_wr_ok = serial_on && (cur_r.mode != MODE_LIMP);
    assign diag_read = serial_on && reg_rd && (reg_addr == `OFS_STD_DIAG);
    assign any_read = serial_on && reg_rd;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 16'h0000;
        case (reg_addr)
            `OFS_STD_DIAG: begin
                rd_val[7:0] = cur_r.fault_mem;
                rd_val[`ON_OPENLOAD_RESULT_BIT] = |cur_r.on_openload_flag_res;
                rd_val[`DIAG_OFF_OPENLOAD_FLAG_BIT] = cur_r.off_openload_flag_flag;
                rd_val[`DIAG_FRAME_BIT] = cur_r.frame_err;
                rd_val[`DIAG_BAT_UV_BIT] = cur_r.bat_uv_flag;
                rd_val[`DIAG_LOW_RANGE_BIT] = cur_r.low_range_flag;
                rd_val[`DIAG_MODE_LSB +: 2] = cur_r.mode;
            end
            `OFS_OUT_CTRL: rd_val[7:0] = cur_r.out_ctrl;
            `OFS_INRUSH: rd_val[7:0] = cur_r.inrush_sel;
            `OFS_MAP0: rd_val[7:0] = cur_r.map0;
            `OFS_MAP1: rd_val[7:0] = cur_r.map1;
            `OFS_IN_STATUS: rd_val[2:0] = {cur_r.in_pins, cur_r.frame_err};
            `OFS_OL_CURRENT: rd_val[7:0] = cur_r.ol_current;
            `OFS_LEVEL_MON: rd_val[7:0] = cur_r.level_mon;
            `OFS_ON_OPENLOAD_FLAG_RES: rd_val[7:0] = cur_r.on_openload_flag_res;
            `OFS_ON_OPENLOAD_FLAG_SEL: rd_val[3:0] = cur_r.on_openload_flag_sel;
            `OFS_HW_CFG: rd_val[3:0] = cur_r.hw_cfg;
            `OFS_LATCH_CLR: rd_val[7:0] = cur_r.latch_clr;
            default: rd_val = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        want_on = 8'h00;
        limp_entry = 1'b0;

        // Three-stage pin capture; a change counts once stages agree
        cur_nxt.sync1 = pins;
        cur_nxt.sync2 = cur_r.sync1;
        cur_nxt.sync3 = cur_r.sync2;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            if (cur_r.sync2[i] == cur_r.sync3[i]) begin
                cur_nxt.filt[i] = cur_r.sync3[i];
            end
        end

        // limp when idle low, an input high and battery ok
        if (!powered) begin
            cur_nxt.mode = MODE_SLEEP;
        end else if (limp_request(idle_in, in0, in1) && vs_ok) begin
            cur_nxt.mode = MODE_LIMP;
        end else if (idle_in && cur_r.hw_cfg[`HW_ACT_BIT]) begin
            cur_nxt.mode = MODE_ACTIVE;
        end else begin
            cur_nxt.mode = MODE_IDLE;
        end
        limp_entry = (cur_nxt.mode == MODE_LIMP) &&
                     (cur_r.mode != MODE_LIMP);

        // Register read answer, one cycle after the strobe
        cur_nxt.rdata = any_read ? rd_val : 16'h0000;

        // Register writes
        if (serial_wr_ok && reg_wr) begin
            case (reg_addr)
                `OFS_OUT_CTRL: cur_nxt.out_ctrl = reg_wdata[7:0];
                `OFS_INRUSH: cur_nxt.inrush_sel = reg_wdata[7:0];
                `OFS_MAP0: cur_nxt.map0 = reg_wdata[7:0];
                `OFS_MAP1: cur_nxt.map1 = reg_wdata[7:0];
                `OFS_OL_CURRENT: cur_nxt.ol_current = reg_wdata[7:0];
                `OFS_ON_OPENLOAD_FLAG_SEL: cur_nxt.on_openload_flag_sel = reg_wdata[3:0];
                `OFS_HW_CFG: cur_nxt.hw_cfg = reg_wdata[3:0];
                `OFS_LATCH_CLR: cur_nxt.latch_clr = reg_wdata[7:0];
                default: cur_nxt.hw_cfg = cur_r.hw_cfg;
            endcase
        end

        // Latch clear empties the fault bit, then drops itself unless that bit's fault event is still present
        cur_nxt.fault_mem = (cur_r.fault_mem & ~cur_r.latch_clr) |
                            fault_event;
        if (!(serial_wr_ok && reg_wr && reg_addr == `OFS_LATCH_CLR)) begin
            cur_nxt.latch_clr = cur_r.latch_clr & fault_event;
        end

        cur_nxt.in_pins = {in1, in0};
        cur_nxt.level_mon = cur_r.filt[`PIN_VOUT_LSB +: 8];

        // Open-load result: reads clear, new events win
        cur_nxt.on_openload_flag_res = cur_r.on_openload_flag_res | on_openload_event;
        if (serial_on && reg_rd && reg_addr == `OFS_ON_OPENLOAD_FLAG_RES) begin
            cur_nxt.on_openload_flag_res = on_openload_event;
        end
        cur_nxt.off_openload_flag_flag = cur_r.off_openload_flag_flag | (|off_openload_event);

        // Frame error shows on the first answer only
        if (any_read) begin
            cur_nxt.frame_err = 1'b0;
        end

        // Supply flags: a diagnostic word read clears, a live condition keeps them set
        if (diag_read) begin
            cur_nxt.low_range_flag = 1'b0;
            cur_nxt.bat_uv_flag = 1'b0;
            cur_nxt.off_openload_flag_flag = |off_openload_event;
        end
        // low window keeps the flag set
        if (cur_r.filt[`PIN_VDD_LOW]) begin
            cur_nxt.low_range_flag = 1'b1;
        end
        if (!vs_ok) begin
            cur_nxt.bat_uv_flag = 1'b1;
        end

        if (limp_entry) begin
            cur_nxt.low_range_flag = 1'b1;
            cur_nxt.bat_uv_flag = 1'b1;
            cur_nxt.on_openload_flag_res = 8'h00;
            cur_nxt.off_openload_flag_flag = 1'b0;
            cur_nxt.frame_err = 1'b1;
        end
        if (cur_nxt.mode == MODE_LIMP) begin
            cur_nxt.ol_current = 8'h00;
        end

        // Channel request
        if (cur_r.mode == MODE_LIMP) begin
            // inputs drive channels 2 and 3
            want_on[2] = in0;
            want_on[3] = in1;
        end else if (cur_r.mode != MODE_SLEEP) begin
            // direct inputs work without logic supply
            want_on = cur_r.out_ctrl | (cur_r.map0 & {8{in0}}) |
                      (cur_r.map1 & {8{in1}});
        end
        want_on = want_on & ~cur_r.fault_mem;
        // on channels ride through a dip
        cur_nxt.chan_on = want_on & (cur_r.chan_on | {8{vs_ok}});

        // fault memory is kept
        // Software reset command also reloads defaults
        if (!vdd_ok || (serial_wr_ok && reg_wr &&
                        reg_addr == `OFS_HW_CFG &&
                        reg_wdata[`HW_RESET_BIT])) begin
            cur_nxt = load_defaults(cur_nxt);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // power-on reset, the only reset that clears fault memory
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_r <= load_defaults('0);
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign reg_rdata = cur_r.rdata;
    assign channel_on = cur_r.chan_on;
    assign inrush_restart_select = cur_r.inrush_sel;
    assign openload_current_enable = cur_r.ol_current;
    assign on_openload_select = cur_r.on_openload_flag_sel;
    assign hardware_configuration = cur_r.hw_cfg;
    assign mode = cur_r.mode;
    assign logic_running = serial_on;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_sleep_no_power: assert property (
        !powered |=> cur_r.mode == MODE_SLEEP)
        else $error("mode not sleep without power");
    chk_limp_entry: assert property (
        powered && vs_ok && limp_request(idle_in, in0, in1)
        |=> cur_r.mode == MODE_LIMP)
        else $error("limp home not entered");
    chk_uv_defaults: assert property (
        !vdd_ok |=> cur_r.out_ctrl == `RST_OUT_CTRL &&
                    cur_r.map0 == `RST_MAP0 && cur_r.map1 == `RST_MAP1)
        else $error("defaults not loaded in undervoltage");
    chk_uv_silent: assert property (
        !vdd_ok && reg_rd |=> reg_rdata == 16'h0000)
        else $error("serial answered in undervoltage");
    chk_fault_kept: assert property (
        !vdd_ok && cur_r.latch_clr == 8'h00
        |=> (cur_r.fault_mem & $past(cur_r.fault_mem)) ==
            $past(cur_r.fault_mem))
        else $error("fault memory lost");
    chk_no_turn_on: assert property (
        !vs_ok |=> (cur_r.chan_on & ~$past(cur_r.chan_on)) == 8'h00)
        else $error("turn-on during battery dip");
    chk_low_range_set: assert property (
        cur_r.filt[`PIN_VDD_LOW] |=> cur_r.low_range_flag)
        else $error("low-range flag not set");
    chk_low_range_clear: assert property (
        $fell(cur_r.low_range_flag) |-> $past(diag_read))
        else $error("low-range flag cleared without read");
    chk_limp_read_only: assert property (
        cur_r.mode == MODE_LIMP && vdd_ok && reg_wr
        ##1 cur_r.mode == MODE_LIMP |-> $stable(cur_r.out_ctrl))
        else $error("write taken in limp home");
    chk_limp_flags: assert property (
        limp_entry |=> cur_r.bat_uv_flag && cur_r.low_range_flag &&
                       cur_r.on_openload_flag_res == 8'h00 &&
                       !cur_r.off_openload_flag_flag && cur_r.frame_err)
        else $error("limp entry flags wrong");

    cov_limp: cover property (limp_entry ##[1:20] cur_r.mode == MODE_IDLE);
    cov_active: cover property (cur_r.mode == MODE_ACTIVE && channel_on != 0);
    cov_diag_read: cover property (diag_read ##1 !cur_r.low_range_flag);
    cov_uv: cover property (vdd_ok ##1 !vdd_ok ##[1:40] vdd_ok);

endmodule : supply_mode_supervisor

`default_nettype wire

// ### supply_mode_supervisor_defines.svh
// Purpose: Offsets, field positions and reset values of the supervisor
// Assumes: Register port with word addresses, 16-bit data
// Notes: Definitions only
`ifndef SUPPLY_MODE_SUPERVISOR_DEFINES_SVH
`define SUPPLY_MODE_SUPERVISOR_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_STD_DIAG 4'h0
`define OFS_OUT_CTRL 4'h1
`define OFS_INRUSH 4'h2
`define OFS_MAP0 4'h3
`define OFS_MAP1 4'h4
`define OFS_IN_STATUS 4'h5
`define OFS_OL_CURRENT 4'h6
`define OFS_LEVEL_MON 4'h7
`define OFS_ON_OPENLOAD_FLAG_RES 4'h8
`define OFS_ON_OPENLOAD_FLAG_SEL 4'h9
`define OFS_HW_CFG 4'ha
`define OFS_LATCH_CLR 4'hb

// ----------------------------------------------------------------
// Standard diagnostic word fields
// ----------------------------------------------------------------
`define ON_OPENLOAD_RESULT_BIT 8
`define DIAG_OFF_OPENLOAD_FLAG_BIT 9
`define DIAG_FRAME_BIT 10
`define DIAG_BAT_UV_BIT 12
`define DIAG_LOW_RANGE_BIT 13
`define DIAG_MODE_LSB 14

// ----------------------------------------------------------------
// Hardware configuration fields
// ----------------------------------------------------------------
`define HW_ACT_BIT 0
`define HW_RESET_BIT 1
`define HW_PAR_LSB 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_OUT_CTRL 8'h00
`define RST_INRUSH 8'h00
`define RST_MAP0 8'h04
`define RST_MAP1 8'h08
`define RST_OL_CURRENT 8'h00
`define RST_LEVEL_MON 8'h00
`define RST_ON_OPENLOAD_FLAG_RES 8'h00
`define RST_ON_OPENLOAD_FLAG_SEL 4'hf
`define RST_HW_CFG 4'h0
`define RST_LATCH_CLR 8'h00

// ----------------------------------------------------------------
// Pin vector positions
// ----------------------------------------------------------------
`define PIN_VDD_OK 0
`define PIN_VDD_LOW 1
`define PIN_VS_OK 2
`define PIN_VS_CRANK 3
`define PIN_IN0 4
`define PIN_IN1 5
`define PIN_IDLE 6
`define PIN_VOUT_LSB 7
`define PIN_COUNT 15

`endif

// ### supply_mode_supervisor_pkg.sv
// Purpose: Types of the supply and mode supervisor
// Assumes: Defines header is available
// Notes: State of the block is one packed struct
`include "supply_mode_supervisor_defines.svh"

package supply_mode_supervisor_pkg;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_IDLE,
        MODE_ACTIVE,
        MODE_LIMP
    } mode_t;

    typedef struct packed {
        logic [`PIN_COUNT-1:0] sync1;
        logic [`PIN_COUNT-1:0] sync2;
        logic [`PIN_COUNT-1:0] sync3;
        logic [`PIN_COUNT-1:0] filt;
        mode_t mode;
        logic low_range_flag;
        logic bat_uv_flag;
        logic frame_err;
        logic off_openload_flag_flag;
        logic [7:0] fault_mem;
        logic [7:0] out_ctrl;
        logic [7:0] inrush_sel;
        logic [7:0] map0;
        logic [7:0] map1;
        logic [1:0] in_pins;
        logic [7:0] ol_current;
        logic [7:0] level_mon;
        logic [7:0] on_openload_flag_res;
        logic [3:0] on_openload_flag_sel;
        logic [3:0] hw_cfg;
        logic [7:0] latch_clr;
        logic [7:0] chan_on;
        logic [15:0] rdata;
    } st_t;

endpackage : supply_mode_supervisor_pkg

// ### host_pin_model.sv
// Purpose: Host side model driving the direct input and idle pins
// Assumes: The host only moves its pins just after a rising edge
// Notes: Requested levels reach the pins one edge later
`timescale 1ns/1ps
`default_nettype none

module host_pin_model (
    // Clock
    input wire logic clk,
    // Requested levels: idle, input 1, input 0
    input wire logic [2:0] req_pins,
    // Pins
    output logic direct_input_0,
    output logic direct_input_1,
    output logic idle_pin
);
    always @(posedge clk) begin
        {idle_pin, direct_input_1, direct_input_0} <= req_pins;
    end
endmodule : host_pin_model

`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench of the supply and mode supervisor
// Assumes: Pins come from host_pin_model, supplies from the bench
// Notes: Eight cycles cover pin filter, mode and channel latency
`timescale 1ns/1ps
`default_nettype none

module tb;
    import supply_mode_supervisor_pkg::*;
    logic clk, sys_rst, vdd_ok, low_lvl, bat_ok, in0, in1, idle;
    logic reg_wr, reg_rd, running;
    logic [2:0] req;
    logic [3:0] reg_addr, ols, hwc;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [7:0] vout, fault_ev, off_openload_flag_ev, on_openload_flag_ev, chan, irs, olc;
    mode_t mode;
    int fail_count, check_count;
    int m_low, m_bat, m_frame, m_off_openload_flag, m_fault, m_mode;
    int dflt[12] = '{0, 0, 0, 4, 8, 0, 0, 0, 0, 15, 0, 0};

    host_pin_model i_host_pin_model (.clk(clk), .req_pins(req),
        .direct_input_0(in0), .direct_input_1(in1), .idle_pin(idle));
    supply_mode_supervisor i_supply_mode_supervisor (.clk(clk),
        .sys_rst(sys_rst), .logic_supply_ok(vdd_ok),
        .logic_supply_low_range_level(low_lvl), .battery_supply_ok(bat_ok),
        .battery_above_crank(1'b1), .direct_input_0(in0),
        .direct_input_1(in1), .idle_pin(idle), .vout_above_threshold(vout),
        .fault_event(fault_ev), .on_openload_event(on_openload_flag_ev),
        .off_openload_event(off_openload_flag_ev), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .channel_on(chan),
        .inrush_restart_select(irs), .openload_current_enable(olc),
        .on_openload_select(ols), .hardware_configuration(hwc),
        .mode(mode), .logic_running(running));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask : rd

    // Model of the diagnostic word; a read clears the sticky flags
    task automatic rd_diag(input logic [15:0] mask);
        logic [15:0] q;
        logic [15:0] e;
        rd(4'h0, q);
        e = 16'((m_mode << 14) | (m_low << 13) | (m_bat << 12) |
                (m_frame << 10) | (m_off_openload_flag << 9) | m_fault);
        check("diag_word", q & mask, e & mask);
        m_low = int'(low_lvl);
        m_bat = int'(!bat_ok);
        m_frame = 0;
        m_off_openload_flag = 0;
    endtask : rd_diag

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run is about 250 cycles
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst, vdd_ok, bat_ok, req} = 6'h3c;
        {low_lvl, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {vout, fault_ev, off_openload_flag_ev, on_openload_flag_ev} = '0;
        {m_low, m_bat, m_frame, m_mode} = {32'd1, 32'd1, 32'd1, 32'd1};
        {m_off_openload_flag, m_fault} = {32'd0, 32'd0};
        void'($urandom(32'h51060914));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        settle(8);
        rd(4'h5, d);
        check("input_status", d, 16'h0001);
        m_frame = 0;
        for (int a = 1; a < 12; a++) begin
            rd(4'(a), d);
            check("reg_default", d, 16'(dflt[a]));
        end
        check("port_default", {irs, olc}, 16'h0000);
        check("sel_cfg", {8'h00, ols, hwc}, 16'h00f0);
        rd_diag(16'hffff);
        rd_diag(16'hffff);
        @(posedge clk);
        low_lvl <= 1'b1;
        settle(8);
        m_low = 1;
        rd_diag(16'hffff);
        rd_diag(16'hffff);
        @(posedge clk);
        low_lvl <= 1'b0;
        settle(8);
        wr(4'h2, 16'h0001);
        rd_diag(16'hffff);
        rd_diag(16'hffff);
        wr(4'ha, 16'h0001);
        settle(2);
        m_mode = 2;
        check("mode", 16'(mode), 16'h0002);
        wr(4'h1, 16'h0001);
        settle(2);
        check("channel_on", 16'(chan), 16'h0001);
        @(posedge clk);
        bat_ok <= 1'b0;
        settle(8);
        m_bat = 1;
        check("channel_on", 16'(chan), 16'h0001);
        wr(4'h1, 16'h0003);
        settle(2);
        check("channel_on", 16'(chan), 16'h0001);
        @(posedge clk);
        {bat_ok, fault_ev, off_openload_flag_ev} <= {1'b1, 8'h02, 8'h01};
        @(posedge clk);
        {fault_ev, off_openload_flag_ev} <= 16'h0000;
        wr(4'h1, 16'h0000);
        settle(2);
        {m_fault, m_off_openload_flag} = {32'd2, 32'd1};
        check("channel_on", 16'(chan), 16'h0000);
        rd_diag(16'hffff);
        @(posedge clk);
        {vdd_ok, bat_ok} <= 2'b00;
        settle(8);
        check("running", 16'(running), 16'h0000);
        rd(4'h0, d);
        check("read_in_uv", d, 16'h0000);
        wr(4'h1, 16'h00ff);
        @(posedge clk);
        {vdd_ok, bat_ok} <= 2'b11;
        settle(8);
        {m_low, m_bat, m_frame} = {32'd1, 32'd1, 32'd1};
        rd_diag(16'h3fff);
        rd(4'h1, d);
        check("out_ctrl", d, 16'h0000);
        @(posedge clk);
        {off_openload_flag_ev, on_openload_flag_ev} <= 16'h0108;
        @(posedge clk);
        {off_openload_flag_ev, on_openload_flag_ev} <= 16'h0000;
        req <= 3'h1;
        settle(8);
        {m_mode, m_low, m_bat} = {32'd3, 32'd1, 32'd1};
        {m_off_openload_flag, m_frame} = {32'd0, 32'd1};
        check("mode", 16'(mode), 16'h0003);
        check("channel_on", 16'(chan), 16'h0004);
        wr(4'h1, 16'h00ff);
        settle(2);
        check("channel_on", 16'(chan), 16'h0004);
        rd_diag(16'hffff);
        rd_diag(16'hffff);
        rd(4'h6, d);
        check("ol_current", d, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            req <= {1'b0, 2'($urandom)};
            vout <= 8'($urandom);
            settle(8);
            check("channel_on", 16'(chan), 16'({req[1:0], 2'b00}));
            check("mode", 16'(mode), 16'(req[1:0] != 0 ? 3 : 0));
            rd(4'h7, d);
            check("level_mon", d, 16'(req[1:0] != 0 ? vout : 8'h00));
        end
        @(posedge clk);
        {req, vdd_ok} <= 4'h2;
        settle(8);
        check("channel_on", 16'(chan), 16'h0004);
        check("running", 16'(running), 16'h0000);
        finish_test();
    end
endmodule : tb

`default_nettype wire
